// >>> core/adc_regs_pkg.sv
// Purpose: Shared constants for the converter result and trigger register block
// Assumes: AXI4-Lite byte addressing, one 32-bit word per register
// Notes:   Byte offsets are four times the register index

package adc_regs_pkg;

  localparam int                ADDR_W = 8;
  localparam int                DATA_W = 32;

  // Register indices
  localparam logic [ADDR_W-1:0] IDX_DIGITAL_INPUT_DISABLE = 8'h01;
  localparam logic [ADDR_W-1:0] IDX_CONVERTER_CONTROL_B   = 8'h03;
  localparam logic [ADDR_W-1:0] IDX_RESULT_LOW            = 8'h04;
  localparam logic [ADDR_W-1:0] IDX_RESULT_HIGH           = 8'h05;
  localparam logic [ADDR_W-1:0] IDX_CONVERTER_CONTROL_A   = 8'h06;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS            = 8'h08;
  localparam logic [ADDR_W-1:0] IDX_IRQ_ENABLE            = 8'h09;
  localparam logic [ADDR_W-1:0] IDX_IRQ_CLEAR             = 8'h0A;

  // Control B fields
  localparam int                CB_BOOST_BIT   = 7;
  localparam int                CB_MUX_EN_BIT  = 6;
  localparam int                CB_RES5_BIT    = 5;
  localparam int                CB_LEFT_BIT    = 4;
  localparam int                CB_RES3_BIT    = 3;
  localparam logic [7:0]        CB_WRITE_MASK  = 8'h7F;

  // Control A fields
  localparam int                CA_ENABLE_BIT  = 7;
  localparam int                CA_START_BIT   = 6;
  localparam int                CA_AUTO_BIT    = 5;
  localparam int                CA_DONE_BIT    = 4;

  // Digital input disable
  localparam logic [7:0]        DID_WRITE_MASK = 8'h3F;

  // Interrupt status bits
  localparam int                IRQ_DONE_BIT    = 0;
  localparam int                IRQ_TRIGGER_BIT = 1;
  localparam int                IRQ_W           = 2;

  localparam logic [7:0]        RESET_BYTE = 8'h00;
  localparam logic [9:0]        RESET_RESULT = 10'h000;

  // Trigger source codes
  typedef enum logic [2:0] {
    TRIG_FREE_RUN  = 3'h0,
    TRIG_COMPARATOR = 3'h1,
    TRIG_EXT_INT0  = 3'h2,
    TRIG_T0_CMP_A  = 3'h3,
    TRIG_T0_OVF    = 3'h4,
    TRIG_T1_CMP_A  = 3'h5,
    TRIG_T1_OVF    = 3'h6,
    TRIG_T1_CMP_B  = 3'h7
  } trigger_source_t;

  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;

endpackage

// >>> core/trigger_select.sv
// Purpose: Picks the auto-trigger flag and detects its rising edge
// Assumes: Flags are synchronous to clock
// Notes:   Select change from a clear to a set flag counts as an edge; a change to free running never does

`timescale 1ns/1ns

module trigger_select
  import adc_regs_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [2:0] trigger_source_select,
  input  wire logic [7:0] trigger_flags,
  input  wire logic       auto_trigger_enable,
  output logic            trigger_edge
);

  logic selected;
  logic selected_prev;

  // Free running has no flag of its own, so its level is zero and cannot rise
  always_comb begin
    if (trigger_source_t'(trigger_source_select) == TRIG_FREE_RUN) begin
      selected = 1'b0; // [RQ10]
    end else begin
      selected = trigger_flags[trigger_source_select]; // [RQ11]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      selected_prev <= 1'b0;
    end else begin
      selected_prev <= selected; // [RQ18]
    end
  end

  assign trigger_edge = auto_trigger_enable & selected & ~selected_prev; // [RQ7] [RQ8] [RQ9] [RQ18]

endmodule

// >>> core/result_present.sv
// Purpose: Formats the 10-bit result into low and high bytes
// Assumes: Adjust select may change at any time
// Notes:   Pure combinational so adjust changes show at once

`timescale 1ns/1ns

module result_present (
  input  wire logic [9:0] result,
  input  wire logic       left_adjust_select,
  output logic      [7:0] low_byte,
  output logic      [7:0] high_byte
);

  always_comb begin
    if (left_adjust_select) begin
      high_byte = result[9:2]; // [RQ1]
      low_byte  = {result[1:0], 6'h00}; // [RQ1]
    end else begin
      high_byte = {6'h00, result[9:8]}; // [RQ2]
      low_byte  = result[7:0]; // [RQ2]
    end
  end

endmodule

// >>> core/adc_result_and_trigger_regs.sv
// Purpose: Register side of a 10-bit converter: result pair, read lock, trigger, input disable
// Assumes: AXI4-Lite slave, synchronous active-high reset, analog core outside
// Notes:   Result pair locks on a low read and unlocks on a high read

`timescale 1ns/1ns

// Behaviour
// RQ1: Left adjust puts bits 9..2 high, bits 1..0 in low bits 7..6.
// RQ2: Right adjust, the reset default, spreads the result across low and high.
// RQ3: Reading low locks the pair; no new result loads until high is read.
// RQ4: Software reads low before high, or only high for 8-bit left adjusted.
// RQ5: Changing adjust select changes the presented result immediately.
// RQ6: Control B bits 5 and 3 store and return whatever software wrote.
// RQ7: Trigger select only matters while auto triggering is enabled.
// RQ8: With auto trigger on, a rising edge of the chosen flag starts conversion.
// RQ9: Switching select from a clear to a set flag counts as an edge.
// RQ10: Switching to free running never creates a trigger event.
// RQ11: Select codes map to free run, comparator, int0, timer0 and timer1 sources.
// RQ12: Each analog disable bit forces that pin's port input to zero.
// RQ13: Input disable has comparator bits 5..4, analog bits 3..0, top two zero.
// RQ14: Software should disable unused analog pin input buffers to save power.
// RQ15: Control B: boost status 7 read-only, mux enable 6, adjust 4, select 2..0.
// RQ16: Writing auto trigger enable one allows automatic starts.
// RQ17: Done flag sets on conversion end with results updated; write one clears. The code sets it on every conversion end, also while the pair is locked.
// RQ18: Trigger detector registers the source and flags a zero-to-one change.
module adc_result_and_trigger_regs
  import adc_regs_pkg::*;
(
  input  wire logic                             clock,
  input  wire logic                             rst,
  // AXI4-Lite slave
  input  wire logic [adc_regs_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [adc_regs_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [adc_regs_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [adc_regs_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  // Analog core
  input  wire logic                             conversion_done,
  input  wire logic [9:0]                       conversion_result,
  output logic                                  conversion_start,
  input  wire logic                             conversion_busy,
  output logic                                  converter_enable,
  output logic                                  comparator_mux_enable,
  // Trigger flags: index 1 comparator, 2 int0, 3..7 timers; index 0 unused
  input  wire logic [7:0]                       trigger_flags,
  input  wire logic                             boost_status,
  // Pins
  input  wire logic [3:0]                       analog_pin_raw,
  output logic      [3:0]                       analog_pin_in,
  output logic      [5:0]                       input_buffer_disable,
  output logic                                  irq
);

  // Write channel holding registers
  logic                 aw_held;
  logic                 w_held;
  logic [ADDR_W-1:0]    aw_addr;
  logic [DATA_W-1:0]    w_data;
  logic [3:0]           w_strb;
  logic                 wr_fire;
  logic [ADDR_W-3:0]    wr_idx;
  logic [ADDR_W-3:0]    rd_idx;
  logic                 rd_fire;
  logic                 wr_byte0;

  // Registers
  logic [7:0]           control_b;
  logic                 auto_trigger_enable;
  logic                 conversion_done_flag;
  logic                 start_pending;
  logic [5:0]           digital_input_disable;
  logic [9:0]           result;
  logic                 pair_locked;
  logic [IRQ_W-1:0]     irq_status;
  logic [IRQ_W-1:0]     irq_enable;
  logic [7:0]           low_byte;
  logic [7:0]           high_byte;
  logic                 trigger_edge;
  logic                 left_adjust_select;
  logic [2:0]           trigger_source_select;
  logic [7:0]           read_byte;
  logic                 read_ok;
  logic                 write_ok;

  // Per-register write and read strobes, high only in the cycle the access executes, plus the Control A read view
  logic                 wr_did;
  logic                 wr_ctrl_a;
  logic                 wr_ctrl_b;
  logic                 wr_irq_enable;
  logic                 wr_irq_clear;
  logic                 sw_start;
  logic                 done_clear;
  logic                 rd_low;
  logic                 rd_high;
  logic [7:0]           control_a_view;

  function automatic logic [ADDR_W-3:0] word_index(input logic [ADDR_W-1:0] addr);
    word_index = addr[ADDR_W-1:2];
  endfunction

  function automatic logic known_index(input logic [ADDR_W-3:0] idx);
    known_index = (idx == IDX_DIGITAL_INPUT_DISABLE[ADDR_W-3:0]) ||
                  (idx == IDX_CONVERTER_CONTROL_B[ADDR_W-3:0])   ||
                  (idx == IDX_RESULT_LOW[ADDR_W-3:0])            ||
                  (idx == IDX_RESULT_HIGH[ADDR_W-3:0])           ||
                  (idx == IDX_CONVERTER_CONTROL_A[ADDR_W-3:0])   ||
                  (idx == IDX_IRQ_STATUS[ADDR_W-3:0])            ||
                  (idx == IDX_IRQ_ENABLE[ADDR_W-3:0])            ||
                  (idx == IDX_IRQ_CLEAR[ADDR_W-3:0]);
  endfunction

  function automatic logic index_hit(input logic [ADDR_W-3:0] idx, input logic [ADDR_W-1:0] target);
    index_hit = (idx == target[ADDR_W-3:0]);
  endfunction

  assign left_adjust_select    = control_b[CB_LEFT_BIT];
  assign trigger_source_select = control_b[2:0];
  assign comparator_mux_enable = control_b[CB_MUX_EN_BIT];

  // AXI write path: address and data accepted independently
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign wr_fire       = aw_held & w_held & ~s_axi_bvalid;
  assign wr_idx        = word_index(aw_addr);
  assign wr_byte0      = wr_fire & w_strb[0];
  assign write_ok      = known_index(wr_idx);

  // Unmapped indices still answer, with an error, and change nothing
  assign wr_did        = wr_byte0 & index_hit(wr_idx, IDX_DIGITAL_INPUT_DISABLE);
  assign wr_ctrl_a     = wr_byte0 & index_hit(wr_idx, IDX_CONVERTER_CONTROL_A);
  assign wr_ctrl_b     = wr_byte0 & index_hit(wr_idx, IDX_CONVERTER_CONTROL_B);
  assign wr_irq_enable = wr_byte0 & index_hit(wr_idx, IDX_IRQ_ENABLE);
  assign wr_irq_clear  = wr_byte0 & index_hit(wr_idx, IDX_IRQ_CLEAR);
  assign sw_start      = wr_ctrl_a & w_data[CA_START_BIT];
  assign done_clear    = wr_ctrl_a & w_data[CA_DONE_BIT];

  always_ff @(posedge clock) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= write_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control B: boost status is live, the rest is storage including reserved 5 and 3
  always_ff @(posedge clock) begin
    if (rst) begin
      control_b <= RESET_BYTE;
    end else if (wr_ctrl_b) begin
      control_b <= w_data[7:0] & CB_WRITE_MASK; // [RQ6] [RQ15]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      digital_input_disable <= 6'h00;
    end else if (wr_did) begin
      digital_input_disable <= w_data[5:0]; // [RQ13]
    end
  end

  assign input_buffer_disable = digital_input_disable;
  assign analog_pin_in        = analog_pin_raw & ~digital_input_disable[3:0]; // [RQ12]

  // Control A: enable, auto trigger and software start
  always_ff @(posedge clock) begin
    if (rst) begin
      converter_enable    <= 1'b0;
      auto_trigger_enable <= 1'b0;
    end else if (wr_ctrl_a) begin
      converter_enable    <= w_data[CA_ENABLE_BIT];
      auto_trigger_enable <= w_data[CA_AUTO_BIT]; // [RQ16]
    end
  end

  // The detector keeps its own history, so a select change is judged against the old level
  trigger_select u_trigger_select (
    .clock                 (clock),
    .rst                   (rst),
    .trigger_source_select (trigger_source_select),
    .trigger_flags         (trigger_flags),
    .auto_trigger_enable   (auto_trigger_enable),
    .trigger_edge          (trigger_edge)
  );

  // One-cycle start pulse; a trigger while disabled is dropped
  always_ff @(posedge clock) begin
    if (rst) begin
      start_pending <= 1'b0;
    end else begin
      start_pending <= converter_enable & ~conversion_busy &
                       (sw_start | trigger_edge); // [RQ8] [RQ9]
    end
  end

  assign conversion_start = start_pending;

  // Done flag: a set in the same cycle as a write-one clear wins
  always_ff @(posedge clock) begin
    if (rst) begin
      conversion_done_flag <= 1'b0;
    end else if (conversion_done) begin
      conversion_done_flag <= 1'b1; // [RQ17]
    end else if (done_clear) begin
      conversion_done_flag <= 1'b0; // [RQ17]
    end
  end

  // Result load is held off while the pair is locked, so a split read stays consistent
  always_ff @(posedge clock) begin
    if (rst) begin
      result <= RESET_RESULT;
    end else if (conversion_done && !pair_locked) begin
      result <= conversion_result; // [RQ3]
    end
  end

  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign rd_idx  = word_index(s_axi_araddr);
  assign rd_low  = rd_fire & index_hit(rd_idx, IDX_RESULT_LOW);
  assign rd_high = rd_fire & index_hit(rd_idx, IDX_RESULT_HIGH);

  // High is checked first, so a lone high read never leaves the pair locked
  always_ff @(posedge clock) begin
    if (rst) begin
      pair_locked <= 1'b0;
    end else if (rd_high) begin
      pair_locked <= 1'b0; // [RQ3]
    end else if (rd_low) begin
      pair_locked <= 1'b1; // [RQ3]
    end
  end

  result_present u_result_present (
    .result             (result),
    .left_adjust_select (left_adjust_select),
    .low_byte           (low_byte),
    .high_byte          (high_byte)
  ); // [RQ5]

  // Interrupt status: sticky, set beats clear
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_status <= '0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if ((i == IRQ_DONE_BIT && conversion_done) || (i == IRQ_TRIGGER_BIT && trigger_edge)) begin
          irq_status[i] <= 1'b1;
        end else if (wr_irq_clear && w_data[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_enable <= '0;
    end else if (wr_irq_enable) begin
      irq_enable <= w_data[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status & irq_enable);

  // Start reads back as busy so software can poll for completion
  assign control_a_view = {converter_enable, conversion_busy | start_pending,
                           auto_trigger_enable, conversion_done_flag, 4'h0};

  // Read path
  always_comb begin
    read_ok   = 1'b1;
    read_byte = RESET_BYTE;
    unique case (rd_idx)
      IDX_DIGITAL_INPUT_DISABLE[ADDR_W-3:0]: read_byte = {2'b00, digital_input_disable}; // [RQ13]
      IDX_CONVERTER_CONTROL_B[ADDR_W-3:0]:   read_byte = {boost_status, control_b[6:0]}; // [RQ15]
      IDX_RESULT_LOW[ADDR_W-3:0]:            read_byte = low_byte;
      IDX_RESULT_HIGH[ADDR_W-3:0]:           read_byte = high_byte;
      IDX_CONVERTER_CONTROL_A[ADDR_W-3:0]:   read_byte = control_a_view;
      IDX_IRQ_STATUS[ADDR_W-3:0]:            read_byte = {6'h00, irq_status};
      IDX_IRQ_ENABLE[ADDR_W-3:0]:            read_byte = {6'h00, irq_enable};
      default:                               read_ok   = 1'b0;
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, read_byte};
      s_axi_rresp  <= read_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> dv/adc_regs_asserts.sv
// Purpose: Port-level assertions for the converter register block
// Assumes: One clock, synchronous active-high reset
// Notes:   Internal registers are hidden, so outputs are tied to port causes

`timescale 1ns/1ns

module adc_regs_asserts
  import adc_regs_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        conversion_start,
  input wire logic        conversion_busy,
  input wire logic        converter_enable,
  input wire logic [3:0]  analog_pin_raw,
  input wire logic [3:0]  analog_pin_in,
  input wire logic [5:0]  input_buffer_disable,
  input wire logic        irq
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (rst);

  AST_PIN_MASK: assert property (analog_pin_in == (analog_pin_raw & ~input_buffer_disable[3:0]))
    else $error("pin input not masked");
  AST_START_ENABLED: assert property (conversion_start |-> $past(converter_enable))
    else $error("start while disabled");
  AST_START_IDLE: assert property (conversion_start |-> !$past(conversion_busy))
    else $error("start while busy");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answered twice");
  AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answered twice");
  AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  AST_AR_READY: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready wrong");
  AST_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");

  cover property (conversion_start);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  cover property (irq);
endmodule

bind adc_result_and_trigger_regs adc_regs_asserts u_asserts (.clock(clock), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .conversion_start(conversion_start), .conversion_busy(conversion_busy),
  .converter_enable(converter_enable), .analog_pin_raw(analog_pin_raw), .analog_pin_in(analog_pin_in),
  .input_buffer_disable(input_buffer_disable), .irq(irq));

// >>> dv/adc_result_and_trigger_regs_tb.sv
// Purpose: Self-checking bench for the converter register block
// Assumes: Byte address is four times the register index
// Notes:   bready and rready stay high, so each response is taken at once

`timescale 1ns/1ns

module adc_result_and_trigger_regs_tb;
  import adc_regs_pkg::*;

  logic             clock = 1'b0;
  logic             rst = 1'b1;
  logic [7:0]       awaddr = 8'h00, araddr = 8'h00, flags = 8'h00;
  logic             awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, done_p = 1'b0, boost = 1'b0, busy = 1'b0;
  logic [31:0]      wdata = 32'h00000000;
  logic [9:0]       result = 10'h000, cur, nxt;
  logic [3:0]       raw = 4'h0;
  wire logic        awready, wready, bvalid, arready, rvalid, start, enable, mux_en, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0]  pin_in;
  wire logic [5:0]  dis;
  integer           errors = 0, n_checks = 0, n_starts = 0, seed = 32'h4a83, s;
  logic [31:0]      rd;
  logic [1:0]       resp;
  logic [15:0]      ex;

  always #2 clock = ~clock;
  always @(posedge clock) if (start) n_starts <= n_starts + 1;

  adc_result_and_trigger_regs dut (.clock(clock), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .conversion_done(done_p),
    .conversion_result(result), .conversion_start(start), .conversion_busy(busy),
    .converter_enable(enable), .comparator_mux_enable(mux_en), .trigger_flags(flags),
    .boost_status(boost), .analog_pin_raw(raw), .analog_pin_in(pin_in), .input_buffer_disable(dis), .irq(irq));

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v, output logic [1:0] r);
    int k;
    awaddr <= {idx[5:0], 2'b00};
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    if (k == 40) begin
      errors++;
      close_out;
    end
  endtask

  task automatic rdx(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    int k;
    araddr <= {idx[5:0], 2'b00};
    arvalid <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    if (k == 40) begin
      errors++;
      close_out;
    end
  endtask

  task automatic wc(input logic [7:0] idx, input logic [7:0] v);
    wr(idx, v, resp);
    check(resp, RESP_OKAY);
  endtask

  task automatic rc(input logic [7:0] idx, input logic [7:0] e);
    rdx(idx, rd, resp);
    check({resp, rd}, {RESP_OKAY, 24'h000000, e});
  endtask

  // Model of the presented pair: {high, low}
  function automatic logic [15:0] pres(input logic [9:0] r, input logic l);
    return l ? {r[9:2], r[1:0], 6'h00} : {6'h00, r[9:8], r[7:0]};
  endfunction

  task automatic convert(input logic [9:0] r);
    result <= r;
    done_p <= 1'b1;
    @(posedge clock);
    done_p <= 1'b0;
    @(posedge clock);
  endtask

  // A start pulse follows a trigger edge by one clock, so four clocks is ample
  task automatic trig(input logic [7:0] f, input integer e);
    s = n_starts;
    flags <= f;
    repeat (4) @(posedge clock);
    check(n_starts - s, e);
  endtask

  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rc(IDX_DIGITAL_INPUT_DISABLE, 8'h00);
    rc(IDX_CONVERTER_CONTROL_B, 8'h00);
    rc(IDX_RESULT_LOW, 8'h00);
    rc(IDX_RESULT_HIGH, 8'h00);
    wc(IDX_DIGITAL_INPUT_DISABLE, 8'hF5);
    rc(IDX_DIGITAL_INPUT_DISABLE, 8'h35);
    check(dis, 6'h35);
    repeat (4) begin
      raw <= 4'($random(seed));
      @(posedge clock);
      check(pin_in, raw & 4'hA);
    end
    boost <= 1'b1;
    wc(IDX_CONVERTER_CONTROL_B, 8'hFF);
    rc(IDX_CONVERTER_CONTROL_B, 8'hFF);
    check(mux_en, 1'b1);
    boost <= 1'b0;
    wc(IDX_CONVERTER_CONTROL_B, 8'h28);
    rc(IDX_CONVERTER_CONTROL_B, 8'h28);
    repeat (3) begin
      cur = 10'($random(seed));
      convert(cur);
      ex = pres(cur, 1'b0);
      rc(IDX_RESULT_LOW, ex[7:0]);
      rc(IDX_RESULT_HIGH, ex[15:8]);
      wc(IDX_CONVERTER_CONTROL_B, 8'h10);
      ex = pres(cur, 1'b1);
      rc(IDX_RESULT_HIGH, ex[15:8]);
      rc(IDX_RESULT_LOW, ex[7:0]);
      rc(IDX_RESULT_HIGH, ex[15:8]);
      wc(IDX_CONVERTER_CONTROL_B, 8'h00);
    end
    cur = 10'($random(seed));
    nxt = ~cur;
    convert(cur);
    ex = pres(cur, 1'b0);
    rc(IDX_RESULT_LOW, ex[7:0]);
    convert(nxt);
    rc(IDX_RESULT_HIGH, ex[15:8]);
    rc(IDX_RESULT_LOW, ex[7:0]);
    rc(IDX_RESULT_HIGH, ex[15:8]);
    convert(nxt);
    ex = pres(nxt, 1'b0);
    rc(IDX_RESULT_LOW, ex[7:0]);
    rc(IDX_RESULT_HIGH, ex[15:8]);
    rc(IDX_CONVERTER_CONTROL_A, 8'h10);
    wc(IDX_CONVERTER_CONTROL_A, 8'h10);
    rc(IDX_CONVERTER_CONTROL_A, 8'h00);
    wc(IDX_IRQ_CLEAR, 8'h03);
    wc(IDX_IRQ_ENABLE, 8'h01);
    check(irq, 1'b0);
    convert(cur);
    check(irq, 1'b1);
    rc(IDX_IRQ_STATUS, 8'h01);
    wc(IDX_IRQ_CLEAR, 8'h03);
    check(irq, 1'b0);
    wc(IDX_IRQ_ENABLE, 8'h00);
    convert(cur);
    check(irq, 1'b0);
    rc(IDX_IRQ_STATUS, 8'h01);
    wc(IDX_IRQ_CLEAR, 8'h03);
    rdx(8'h02, rd, resp);
    check(resp, RESP_SLVERR);
    wr(8'h02, 8'hFF, resp);
    check(resp, RESP_SLVERR);
    wc(IDX_CONVERTER_CONTROL_A, 8'hB0);
    rc(IDX_CONVERTER_CONTROL_A, 8'hA0);
    check(enable, 1'b1);
    for (int c = 1; c < 8; c++) begin
      wc(IDX_CONVERTER_CONTROL_B, 8'(c));
      trig(8'hFE & ~(8'h01 << c), 0);
      trig(8'hFE, 1);
      trig(8'h00, 0);
    end
    trig(8'hFE, 1);
    trig(8'h00, 0);
    busy <= 1'b1;
    trig(8'hFE, 0);
    busy <= 1'b0;
    wc(IDX_CONVERTER_CONTROL_B, 8'h00);
    trig(8'h00, 0);
    trig(8'hFF, 0);
    trig(8'h08, 0);
    s = n_starts;
    wc(IDX_CONVERTER_CONTROL_B, 8'h02);
    wc(IDX_CONVERTER_CONTROL_B, 8'h03);
    repeat (3) @(posedge clock);
    check(n_starts - s, 1);
    wc(IDX_CONVERTER_CONTROL_A, 8'h80);
    trig(8'h00, 0);
    trig(8'hFE, 0);
    close_out;
  end
endmodule
